// ===== hdl/poi_top.sv
// Output and interlock logic of a four-division protection system.
// Assumes all plant inputs synchronous to clock; trip inputs active high.
`timescale 1ns/1ps
module poi_top
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // AHB-Lite
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Plant inputs
   input wire poi_pkg::poi_in_t plant_in,
   input wire logic [31:0] param_values,
   // Plant outputs
   output poi_pkg::poi_out_t plant_out,
   output poi_pkg::poi_alarm_t alarm,
   output poi_pkg::poi_event_t event_rec
);
   ////////////////////////////////////////////////////////////////////////////////
   // Register bus
   logic wr_en;
   logic rd_en;
   logic [7:0] reg_addr;
   logic [31:0] wr_data;
   logic [31:0] ctrl;
   logic [7:0] threshold;
   logic [31:0] status_word;

   poi_ahb_slave u_bus
   (
      .clock(clock),
      .sys_rst(sys_rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hready(hready),
      .hwdata(hwdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .wr_en(wr_en),
      .reg_addr(reg_addr),
      .wr_data(wr_data),
      .rd_en(rd_en)
   );

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         ctrl <= poi_pkg::ctrl_rst;
         threshold <= poi_pkg::pass_threshold_rst;
      end
      else if (wr_en)
      begin
         case (reg_addr)
            poi_pkg::addr_ctrl: ctrl <= wr_data;
            poi_pkg::addr_threshold: threshold <= wr_data[7:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Input sampling
   // RL19: Register all inputs
   poi_pkg::poi_in_t smp;
   logic [31:0] smp_param;
   logic evaluated;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         smp <= '0;
         smp_param <= 32'h0000_0000;
         evaluated <= 1'b0;
      end
      else
      begin
         smp <= plant_in;
         smp_param <= param_values;
         evaluated <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Trip decision
   logic [3:0] chan_trip;
   logic [2:0] auto_count;
   logic auto_scram;
   logic manual_scram;
   logic full_scram;
   logic in_run;
   logic in_startup_run;

   // RL18: Lost link is trip
   assign chan_trip = smp.auto_trip | ~smp.link_ok;

   always_comb
   begin
      auto_count = 3'b000;
      for (int i = 0; i < poi_pkg::num_div; i++)
         auto_count = auto_count + {2'b00, chan_trip[i]};
   end

   // RL1: Two of four
   assign auto_scram = auto_count >= poi_pkg::vote_min;
   // RL2: Both manual channels
   assign manual_scram = &smp.manual_trip;
   assign full_scram = auto_scram || manual_scram || !ctrl[poi_pkg::ctrl_dev_en_bit];
   assign in_run = smp.mode == poi_pkg::poi_mode_run;
   assign in_startup_run = in_run || smp.mode == poi_pkg::poi_mode_startup;

   ////////////////////////////////////////////////////////////////////////////////
   // Actuation outputs
   // RL20: Safe during reset
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         plant_out <= '0;
         plant_out.backup_valve <= 2'b11;
         plant_out.scram_follow <= 1'b1;
         plant_out.rod_block <= 4'hF;
      end
      else if (!evaluated)
      begin
         plant_out <= '0;
         plant_out.backup_valve <= 2'b11;
         plant_out.scram_follow <= 1'b1;
         plant_out.rod_block <= 4'hF;
      end
      else
      begin
         // RL1: Actuator power removal
         plant_out.actuator_power <= !full_scram;
         // RL3: Both backup valves
         plant_out.backup_valve <= {2{full_scram}};
         // RL4: Run indication
         plant_out.run_to_neutron_monitor <= {4{in_run}};
         // RL5: Scram follow
         plant_out.scram_follow <= full_scram;
         // RL6: Test switches and mode
         plant_out.scram_test_to_rcs <= smp.scram_test;
         plant_out.mode_to_rcs <= smp.mode;
         // RL7: Rod withdrawal inhibit
         plant_out.rod_block <= {4{smp.header_low || |smp.header_bypass}};
         // RL8: Mode to leak isolation
         plant_out.mode_to_leak <= smp.mode;
         // RL9: Steam isolation bypass
         plant_out.steam_iso_bypass <= !in_run;
         // RL16: Condenser permissive
         plant_out.cond_permissive <= {4{in_run}};
         // RL17: Automation outputs
         plant_out.mode_to_pas <= smp.mode;
         plant_out.auto_scram_to_pas <= auto_scram;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Deviation checks
   logic [3:0] dev;

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_dev
         poi_deviation u_dev
         (
            .clock(clock),
            .sys_rst(sys_rst),
            .own_value(smp_param[8*g +: 8]),
            .other_a(smp_param[8*((g+1)%4) +: 8]),
            .other_b(smp_param[8*((g+2)%4) +: 8]),
            .other_c(smp_param[8*((g+3)%4) +: 8]),
            .threshold(threshold),
            .deviates(dev[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Alarms
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         alarm <= '0;
         alarm.sensor <= 4'hF;
         alarm.auto_sys <= 1'b1;
         alarm.manual_sys <= 1'b1;
      end
      // RL20: Alarms held until evaluated
      else if (!evaluated)
      begin
         alarm <= '0;
         alarm.sensor <= 4'hF;
         alarm.auto_sys <= 1'b1;
         alarm.manual_sys <= 1'b1;
      end
      else
      begin
         // RL11: Trip and bypass alarms
         alarm.sensor <= smp.sensor_trip;
         alarm.auto_sys <= auto_scram;
         alarm.manual_sys <= manual_scram;
         alarm.bypass_any <= |smp.bypass || |smp.header_bypass;
         // RL10: Deviation alarm
         alarm.deviation <= |dev;
         // RL12: Header bypass in mode
         alarm.header_bypass_mode <= |smp.header_bypass && in_startup_run;
         // RL13: Non-coincident in Run
         alarm.noncoinc_in_run <= smp.noncoinc_mode && in_run;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event logging
   logic [3:0] prev_trip;
   logic [3:0] prev_byp;
   logic prev_manual;
   logic [3:0] new_trip;
   logic [3:0] cleared;
   logic [3:0] new_byp;
   logic [3:0] new_unbyp;
   logic [1:0] first_chan;

   assign new_trip = chan_trip & ~prev_trip;
   assign cleared = ~chan_trip & prev_trip;
   assign new_byp = smp.bypass & ~prev_byp;
   // Bypass removal is logged as a reset
   assign new_unbyp = ~smp.bypass & prev_byp;

   always_comb
   begin
      first_chan = 2'b00;
      for (int i = 3; i >= 0; i--)
         if (new_trip[i] || cleared[i] || new_byp[i] || new_unbyp[i])
            first_chan = i[1:0];
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         prev_trip <= 4'h0;
         prev_byp <= 4'h0;
         prev_manual <= 1'b0;
         event_rec <= '0;
      end
      // RL20: No events from reset samples
      else if (evaluated)
      begin
         prev_trip <= chan_trip;
         prev_byp <= smp.bypass;
         prev_manual <= manual_scram;
         event_rec.valid <= 1'b0;
         // RL14: Transition reporting
         // RL15: Identify variable channel system
         if (manual_scram != prev_manual)
         begin
            event_rec.valid <= 1'b1;
            event_rec.kind <= manual_scram ? poi_pkg::ev_tripped : poi_pkg::ev_reset;
            event_rec.variable <= smp.sensor_trip;
            event_rec.channel <= 2'b00;
            event_rec.trip_system <= 1'b1;
         end
         else if (|new_trip || |cleared || |new_byp || |new_unbyp)
         begin
            event_rec.valid <= 1'b1;
            event_rec.kind <= |new_trip ? poi_pkg::ev_tripped :
                              (|new_byp ? poi_pkg::ev_bypassed : poi_pkg::ev_reset);
            event_rec.variable <= smp.sensor_trip;
            event_rec.channel <= first_chan;
            event_rec.trip_system <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data
   assign status_word = {16'h0000, plant_out.actuator_power, full_scram, auto_scram,
                         manual_scram, chan_trip, smp.bypass, smp.mode, 2'b00};

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         hrdata <= 32'h0000_0000;
      else if (rd_en)
      begin
         // Live address phase, so a write data phase cannot steer it
         case (haddr[7:0])
            poi_pkg::addr_ctrl: hrdata <= ctrl;
            poi_pkg::addr_threshold: hrdata <= {24'h00_0000, threshold};
            poi_pkg::addr_status: hrdata <= status_word;
            poi_pkg::addr_alarm: hrdata <= {22'h00_0000, alarm};
            poi_pkg::addr_event: hrdata <= {22'h00_0000, event_rec};
            poi_pkg::addr_param0: hrdata <= smp_param;
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule : poi_top

// ===== hdl/poi_pkg.sv
// Constants, types and register map of the protection output interlock.
// Assumes one 20 MHz clock, synchronous active-high reset, AHB-Lite register access.
// Functional notes
// RL1: De-energise actuator power when two or more of four automatic channels trip.
// RL2: De-energise actuator power when both manual trip channels are tripped.
// RL3: Actuate both backup scram valves together with actuator de-energisation.
// RL4: Run indication to each of four neutron monitor divisions exactly in Run.
// RL5: Assert scram-follow to the rod control system on any full scram.
// RL6: Report both scram test switches and mode position to rod control.
// RL7: Rod withdrawal inhibit per channel on header low pressure or bypass.
// RL8: Send per-division mode status to the leak isolation system.
// RL9: Steam isolation bypass interlock only while mode is outside Run.
// RL10: Alarm when a division's parameter deviates from the other three beyond threshold.
// RL11: Alarms for sensor channel trips, each trip system, and any bypass.
// RL12: Alarm when header trip bypass stays set in Startup or Run.
// RL13: Alarm on non-coincident neutron trip mode while in Run.
// RL14: Log tripped, bypassed and reset transitions to the plant computer; one event per cycle, manual_scram changes mask channel changes.
// RL15: Per trip event give variable, channel and trip system identity.
// RL16: Condenser control permissive in Run, inhibit in other three positions.
// RL17: Forward mode position and automatic scram separately to plant automation.
// RL18: Loss of any communication link or fiber input counts as a trip.
// RL19: Inputs sampled and outputs registered on one clock, bounded latency.
// RL20: During reset hold actuators de-energised and trip alarms asserted.
package poi_pkg;
   localparam int unsigned clock_hz = 20_000_000;
   localparam int unsigned num_div = 4;
   localparam logic [7:0] pass_threshold_rst = 8'h10;
   // Tripped automatic channels needed for a scram
   localparam logic [2:0] vote_min = 3'h2;
   // Mode selector codes
   typedef enum logic [1:0] {
      poi_mode_shutdown = 2'b00,
      poi_mode_refuel = 2'b01,
      poi_mode_startup = 2'b10,
      poi_mode_run = 2'b11
   } poi_mode_t;
   // Register byte addresses
   localparam logic [7:0] addr_ctrl = 8'h00;
   localparam logic [7:0] addr_threshold = 8'h04;
   localparam logic [7:0] addr_status = 8'h08;
   localparam logic [7:0] addr_alarm = 8'h0C;
   localparam logic [7:0] addr_event = 8'h10;
   localparam logic [7:0] addr_param0 = 8'h14;
   // Control register fields
   localparam int unsigned ctrl_dev_en_bit = 0;
   localparam logic [31:0] ctrl_rst = 32'h0000_0001;
   // Plant-side inputs
   typedef struct packed {
      logic [3:0] auto_trip;
      logic [1:0] manual_trip;
      logic [3:0] sensor_trip;
      logic [3:0] link_ok;
      logic [3:0] bypass;
      logic [3:0] header_bypass;
      logic header_low;
      logic [1:0] scram_test;
      logic noncoinc_mode;
      poi_mode_t mode;
   } poi_in_t;
   // Plant-side outputs
   typedef struct packed {
      logic actuator_power;
      logic [1:0] backup_valve;
      logic [3:0] run_to_neutron_monitor;
      logic scram_follow;
      logic [1:0] scram_test_to_rcs;
      poi_mode_t mode_to_rcs;
      logic [3:0] rod_block;
      poi_mode_t mode_to_leak;
      logic steam_iso_bypass;
      logic [3:0] cond_permissive;
      poi_mode_t mode_to_pas;
      logic auto_scram_to_pas;
   } poi_out_t;
   // Alarm word layout, high bits first
   typedef struct packed {
      logic noncoinc_in_run;
      logic header_bypass_mode;
      logic deviation;
      logic bypass_any;
      logic manual_sys;
      logic auto_sys;
      logic [3:0] sensor;
   } poi_alarm_t;
   // Logged event record
   typedef struct packed {
      logic valid;
      logic [1:0] kind;
      logic [3:0] variable;
      logic [1:0] channel;
      logic trip_system;
   } poi_event_t;
   localparam logic [1:0] ev_tripped = 2'b01;
   localparam logic [1:0] ev_bypassed = 2'b10;
   localparam logic [1:0] ev_reset = 2'b11;
endpackage : poi_pkg

// ===== hdl/poi_deviation.sv
// One division's deviation check against the other three.
// Assumes unsigned eight-bit parameter values, all on the same clock.
`timescale 1ns/1ps
module poi_deviation
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Values
   input wire logic [7:0] own_value,
   input wire logic [7:0] other_a,
   input wire logic [7:0] other_b,
   input wire logic [7:0] other_c,
   input wire logic [7:0] threshold,
   // Result
   output logic deviates
);
   function automatic logic [7:0] absdiff(input logic [7:0] a, input logic [7:0] b);
      absdiff = (a > b) ? a - b : b - a;
   endfunction : absdiff

   // RL10: Beyond all three
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         deviates <= 1'b0;
      else
         deviates <= (absdiff(own_value, other_a) > threshold) &&
                     (absdiff(own_value, other_b) > threshold) &&
                     (absdiff(own_value, other_c) > threshold);
   end
endmodule : poi_deviation

// ===== hdl/poi_ahb_slave.sv
// AHB-Lite slave front end: latches address phase, gives one-cycle write/read strobes.
// Assumes single whole-word transfers; response always OKAY, zero wait states.
`timescale 1ns/1ps
module poi_ahb_slave
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // AHB-Lite
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   // Register side
   output logic wr_en,
   output logic [7:0] reg_addr,
   output logic [31:0] wr_data,
   output logic rd_en
);
   logic pend_write;
   logic [7:0] pend_addr;
   logic active;

   assign active = hsel && hready && htrans[1];

   // Address phase capture
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         pend_write <= 1'b0;
         pend_addr <= 8'h00;
      end
      else
      begin
         pend_write <= active && hwrite;
         if (active)
            pend_addr <= haddr[7:0];
      end
   end

   assign wr_en = pend_write;
   assign wr_data = hwdata;
   // Write address only; a new address phase must not steer a pending write
   assign reg_addr = pend_addr;
   assign rd_en = active && !hwrite;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule : poi_ahb_slave

// ===== verif/poi_monitor.sv
// Concurrent checks on the plant ports of the protection output interlock.
// Assumes outputs follow sampled inputs two clock edges later.
`timescale 1ns/1ps
module poi_monitor
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Plant side
   input wire poi_pkg::poi_in_t plant_in,
   input wire poi_pkg::poi_out_t plant_out,
   input wire poi_pkg::poi_alarm_t alarm,
   input wire poi_pkg::poi_event_t event_rec
);
   logic [1:0] age;
   logic settled, in_run, two_vote, manual_both, header_req, hdr_cond, nc_cond;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////
   // Cycles since reset release
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         age <= 2'h0;
      else if (age != 2'h3)
         age <= age + 2'h1;
   end
   assign settled = (age >= 2'h2);
   assign in_run = (plant_in.mode == poi_pkg::poi_mode_run);
   assign two_vote = ($countones(plant_in.auto_trip | ~plant_in.link_ok) >= 2);
   assign manual_both = &plant_in.manual_trip;
   assign header_req = plant_in.header_low | (|plant_in.header_bypass);
   assign hdr_cond = (|plant_in.header_bypass) & plant_in.mode[1];
   assign nc_cond = plant_in.noncoinc_mode & in_run;
   ////////////////////////////////////////
   sequence auto_rise_s;
      settled && (((plant_in.auto_trip | ~plant_in.link_ok) &
      ~$past(plant_in.auto_trip | ~plant_in.link_ok)) != 4'h0);
   endsequence
   sequence logged_s;
      ##2 event_rec.valid;
   endsequence
   trip_vote_a: assert property (
      settled && $past(two_vote, 2) |->
      !plant_out.actuator_power && plant_out.auto_scram_to_pas) else $error("no auto scram");
   manual_pair_a: assert property (
      settled && $past(manual_both, 2) |-> !plant_out.actuator_power) else $error("no manual scram");
   backup_pair_a: assert property (
      plant_out.backup_valve == {2{!plant_out.actuator_power}}) else $error("backup valves");
   run_indicate_a: assert property (
      settled |-> plant_out.run_to_neutron_monitor == {4{$past(in_run, 2)}} &&
      plant_out.cond_permissive == {4{$past(in_run, 2)}}) else $error("run indication");
   follow_scram_a: assert property (
      settled |-> plant_out.scram_follow == !plant_out.actuator_power) else $error("scram follow");
   rod_inhibit_a: assert property (
      settled |-> plant_out.rod_block == {4{$past(header_req, 2)}}) else $error("rod block");
   mode_relay_a: assert property (
      settled |-> {plant_out.scram_test_to_rcs, plant_out.mode_to_rcs, plant_out.mode_to_leak,
      plant_out.mode_to_pas} == {$past(plant_in.scram_test, 2), {3{$past(plant_in.mode, 2)}}})
      else $error("mode relay");
   steam_bypass_a: assert property (
      settled |-> plant_out.steam_iso_bypass == !$past(in_run, 2)) else $error("steam bypass");
   startup_bypass_a: assert property (
      settled |-> alarm.header_bypass_mode == $past(hdr_cond, 2)) else $error("header alarm");
   noncoinc_run_a: assert property (
      settled |-> alarm.noncoinc_in_run == $past(nc_cond, 2)) else $error("noncoinc alarm");
   sensor_alarm_a: assert property (
      settled |-> alarm.sensor == $past(plant_in.sensor_trip, 2)) else $error("sensor alarm");
   event_log_a: assert property (
      auto_rise_s |-> logged_s) else $error("trip not logged");
   reset_safe_a: assert property (disable iff (1'b0) sys_rst |=>
      !plant_out.actuator_power && alarm.sensor == 4'hF && alarm.auto_sys && alarm.manual_sys)
      else $error("unsafe in reset");
endmodule : poi_monitor
bind poi_top poi_monitor poi_monitor_i (.clock(clock), .sys_rst(sys_rst),
   .plant_in(plant_in), .plant_out(plant_out), .alarm(alarm), .event_rec(event_rec));

// ===== verif/poi_plant_model.sv
// Far-side model: logging computer and rod control fed by the interlock.
// Assumes event records pulse for one cycle on the shared clock.
`timescale 1ns/1ps
module poi_plant_model
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // From the interlock
   input wire poi_pkg::poi_out_t plant_out,
   input wire poi_pkg::poi_event_t event_rec,
   // Observed state
   output logic [7:0] event_count,
   output poi_pkg::poi_event_t last_event,
   output logic rods_in
);
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         event_count <= 8'h00;
         last_event <= '0;
      end
      else if (event_rec.valid)
      begin
         event_count <= event_count + 8'h01;
         last_event <= event_rec;
      end
   end
   always_ff @(posedge clock)
   begin
      if (plant_out.scram_follow)
         rods_in <= 1'b1;
      else if (plant_out.actuator_power)
         rods_in <= 1'b0;
   end
endmodule : poi_plant_model

// ===== verif/tb.sv
// Self-checking bench of the protection output interlock.
// Assumes zero-wait bus answers and two-edge plant latency.
`timescale 1ns/1ps
module tb;
   typedef struct packed {
      poi_pkg::poi_in_t stim;
      logic [8:0] expect_out;
   } poi_row_t;
   logic clock, sys_rst, hsel, hwrite, hreadyout, hresp, rods_in;
   logic [31:0] haddr, hwdata, hrdata, param_values, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] event_count, n;
   poi_pkg::poi_in_t plant_in;
   poi_pkg::poi_out_t plant_out;
   poi_pkg::poi_alarm_t alarm;
   poi_pkg::poi_event_t event_rec, last_event;
   poi_row_t rows[8];
   int bad_count, samples_checked;
   poi_top poi_top_i (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .plant_in(plant_in),
      .param_values(param_values), .plant_out(plant_out), .alarm(alarm), .event_rec(event_rec));
   poi_plant_model poi_plant_model_i (.clock(clock), .sys_rst(sys_rst), .plant_out(plant_out),
      .event_rec(event_rec), .event_count(event_count), .last_event(last_event), .rods_in(rods_in));
   ////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic wait_out(input int cycles);
      repeat (cycles) @(posedge clock);
      #1;
   endtask : wait_out
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   function automatic poi_row_t row(input logic [3:0] at, lk, hb, input logic [1:0] mt,
      input logic hl, input logic [1:0] md, input logic [8:0] ex);
      poi_row_t r;
      r = '0;
      r.stim = {at, mt, at, lk, hb, hb, hl, md, 1'b1, poi_pkg::poi_mode_t'(md)};
      r.expect_out = ex;
      return r;
   endfunction : row
   task automatic tally_and_finish();
      if (bad_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial
   begin
      repeat (3000) @(posedge clock);
      bad_count++;
      tally_and_finish();
   end
   initial
   begin
      {sys_rst, hsel, hwrite, htrans, hsize, haddr, hwdata} = {1'b1, 71'h0};
      param_values = 32'h2020_2020;
      rows = '{row(4'h0, 4'hF, 4'h0, 2'h0, 1'b0, 2'h3, 9'h10F),
         row(4'h3, 4'hF, 4'h0, 2'h0, 1'b0, 2'h3, 9'h00F), row(4'h8, 4'hF, 4'h0, 2'h0, 1'b0, 2'h2, 9'h100),
         row(4'h1, 4'hB, 4'h0, 2'h0, 1'b0, 2'h3, 9'h00F), row(4'h0, 4'hF, 4'h0, 2'h3, 1'b0, 2'h0, 9'h000),
         row(4'h0, 4'hF, 4'h0, 2'h1, 1'b0, 2'h1, 9'h100), row(4'hF, 4'hF, 4'h0, 2'h0, 1'b1, 2'h2, 9'h0F0),
         row(4'h0, 4'hF, 4'h4, 2'h0, 1'b0, 2'h2, 9'h1F0)};
      plant_in = rows[0].stim;
      wait_out(11);
      check({plant_out.actuator_power, alarm.sensor}, 32'h0000_000F);
      @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      ahb(1'b0, poi_pkg::addr_ctrl, 32'h0);
      check(rd, poi_pkg::ctrl_rst);
      check(hresp, 32'h0);
      ahb(1'b0, poi_pkg::addr_threshold, 32'h0);
      check(rd, {24'h00_0000, poi_pkg::pass_threshold_rst});
      ahb(1'b1, poi_pkg::addr_threshold, 32'h0000_0020);
      ahb(1'b0, poi_pkg::addr_threshold, 32'h0);
      check(rd, 32'h0000_0020);
      ahb(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0000_0000);
      ahb(1'b1, poi_pkg::addr_ctrl, 32'h0);
      wait_out(3);
      check({plant_out.actuator_power, plant_out.backup_valve, rods_in}, 32'h0000_0007);
      ahb(1'b1, poi_pkg::addr_ctrl, poi_pkg::ctrl_rst);
      foreach (rows[i])
      begin
         plant_in <= rows[i].stim;
         wait_out(3);
         rd = {plant_out.actuator_power, plant_out.rod_block, plant_out.run_to_neutron_monitor};
         check(rd, rows[i].expect_out);
         check(plant_out.cond_permissive, rows[i].expect_out[3:0]);
         rd = {rows[i].stim.mode >= poi_pkg::poi_mode_startup, 1'b1} & {2{|rows[i].stim.bypass}};
         check({alarm.header_bypass_mode, alarm.bypass_any}, rd);
         @(posedge clock);
      end
      plant_in <= rows[0].stim;
      param_values <= 32'h2041_2020;
      wait_out(4);
      check(alarm.deviation, 32'h1);
      @(posedge clock);
      param_values <= 32'h2040_2020;
      wait_out(4);
      check(alarm.deviation, 32'h0);
      n = event_count;
      @(posedge clock);
      plant_in.auto_trip <= 4'h4;
      wait_out(4);
      check(event_count, n + 8'h01);
      rd = {poi_pkg::ev_tripped, 2'h2, 1'b0};
      check({last_event.kind, last_event.channel, last_event.trip_system}, rd);
      @(posedge clock);
      plant_in.manual_trip <= 2'h3;
      wait_out(4);
      check({last_event.trip_system, alarm.manual_sys, rods_in}, 32'h0000_0007);
      @(posedge clock);
      plant_in <= rows[0].stim;
      sys_rst <= 1'b1;
      wait_out(2);
      check({plant_out.actuator_power, alarm.auto_sys}, 32'h0000_0001);
      @(posedge clock);
      sys_rst <= 1'b0;
      wait_out(4);
      check(plant_out.actuator_power, 32'h1);
      tally_and_finish();
   end
endmodule : tb
